// File: iopfs_defines.svh
// Register offsets, field positions and reset values of the pin function
// select block. Assumes a Wishbone slave with 8-bit registers in words.
// Operation
// - Data filter used unless bit 3 set
// - Clock filter used unless bit 2 set
// - Bit 1 selects GPIO or I2C pins
// - I2C select resets zero, standby powered
// - Bit 7 sets group two drive type
// - Bit 6 sets group one drive type
// - Bit 2 enables thermal shutdown, battery-backed
// - Field 00: tri-state, low, six GPIO
// - Field 01: infrared receive and transmit
// - Field 10 all GPIO, 11 serial port
// - Bits 6..4 disable debouncers of 27..25
// - Bits 2..0 select level trigger
// - Debounce register resets to zero
`ifndef IOPFS_DEFINES_SVH
`define IOPFS_DEFINES_SVH
`define IOPFS_IDX_I2C_SEL 8'h2a
`define IOPFS_IDX_RSVD 8'h2b
`define IOPFS_IDX_OUT_FUNC 8'h2c
`define IOPFS_IDX_DEB_TRIG 8'h2d
`define IOPFS_I2C_SEL_MASK 8'h0e
`define IOPFS_OUT_FUNC_MASK 8'hc7
`define IOPFS_DEB_TRIG_MASK 8'h77
`define IOPFS_I2C_SEL_RESET 8'h00
`define IOPFS_OUT_FUNC_RESET 8'h00
`define IOPFS_DEB_TRIG_RESET 8'h00
`define IOPFS_BIT_SDA_BYPASS 3
`define IOPFS_BIT_SCL_BYPASS 2
`define IOPFS_BIT_I2C_PINS 1
`define IOPFS_BIT_G2_PUSHPULL 7
`define IOPFS_BIT_G1_PUSHPULL 6
`define IOPFS_BIT_THERM_EN 2
`define IOPFS_FUNC_HI 1
`define IOPFS_FUNC_LO 0
`define IOPFS_DEB_LO 4
`define IOPFS_TRIG_LO 0
`endif

// File: iopfs_pkg.sv
// Types of the pin function select block.
// Assumes the defines header supplies all numbers.
package iopfs_pkg;
	typedef enum logic [1:0] {
		IOPFS_BANK_RESERVED,
		IOPFS_BANK_INFRARED,
		IOPFS_BANK_GPIO,
		IOPFS_BANK_SERIAL
	} iopfs_bank_t;
	typedef struct packed {
		logic [7:0] adr;
		logic [7:0] dat;
		logic we;
		logic sel;
		logic cyc;
		logic stb;
	} iopfs_wb_req_t;
	typedef struct packed {
		logic sda_bypass;
		logic scl_bypass;
		logic i2c_pins;
		logic group_two_push_pull;
		logic group_one_push_pull;
		logic thermal_shutdown_enable;
		iopfs_bank_t bank_function;
		logic [2:0] debounce_disable;
		logic [2:0] level_trigger;
	} iopfs_cfg_t;
endpackage : iopfs_pkg

// File: iopfs_top.sv
// Wishbone-reached configuration registers steering shared pin functions.
// Assumes a classic Wishbone master on clk; pins handled by pad logic.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "iopfs_defines.svh"
module iopfs_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Wishbone slave
	input wire iopfs_pkg::iopfs_wb_req_t wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pin routing controls
	output iopfs_pkg::iopfs_cfg_t cfg,
	// Eight-pin bank: per pin GPIO, infrared, serial, tri-state or low
	output logic [7:0] bank_gpio_sel,
	output logic [7:0] bank_serial_sel,
	output logic bank_pin0_tristate,
	output logic bank_pin1_force_low,
	output logic bank_ir_sel
);
	import iopfs_pkg::*;

	logic [7:0] i2c_pin_select;
	logic [7:0] output_type_pin_function;
	logic [7:0] debounce_trigger_select;
	logic access;
	logic wr;
	logic [7:0] next_rdata;
	iopfs_bank_t bank;

	assign access = wb_req.cyc && wb_req.stb && !wb_ack_o;
	assign wr = access && wb_req.we && wb_req.sel;

	// Standby-domain register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			i2c_pin_select <= `IOPFS_I2C_SEL_RESET;
		end else if (wr && wb_req.adr == `IOPFS_IDX_I2C_SEL) begin
			i2c_pin_select <= wb_req.dat & `IOPFS_I2C_SEL_MASK;
		end
	end

	// Battery-backed drive type and bank function register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			output_type_pin_function <= `IOPFS_OUT_FUNC_RESET;
		end else if (wr && wb_req.adr == `IOPFS_IDX_OUT_FUNC) begin
			output_type_pin_function <= wb_req.dat & `IOPFS_OUT_FUNC_MASK;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			debounce_trigger_select <= `IOPFS_DEB_TRIG_RESET;
		end else if (wr && wb_req.adr == `IOPFS_IDX_DEB_TRIG) begin
			debounce_trigger_select <= wb_req.dat & `IOPFS_DEB_TRIG_MASK;
		end
	end

	// Read mux; unmapped and reserved offsets answer zero
	always_comb begin
		case (wb_req.adr)
			`IOPFS_IDX_I2C_SEL: next_rdata = i2c_pin_select;
			`IOPFS_IDX_OUT_FUNC: next_rdata = output_type_pin_function;
			`IOPFS_IDX_DEB_TRIG: next_rdata = debounce_trigger_select;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= access ? {24'h00_0000, next_rdata} : 32'h0000_0000;
		end
	end

	assign bank = iopfs_bank_t'(output_type_pin_function[`IOPFS_FUNC_HI:
		`IOPFS_FUNC_LO]);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= '0;
		end else begin
			cfg.sda_bypass <= i2c_pin_select[`IOPFS_BIT_SDA_BYPASS];
			cfg.scl_bypass <= i2c_pin_select[`IOPFS_BIT_SCL_BYPASS];
			cfg.i2c_pins <= i2c_pin_select[`IOPFS_BIT_I2C_PINS];
			cfg.group_two_push_pull <=
				output_type_pin_function[`IOPFS_BIT_G2_PUSHPULL];
			cfg.group_one_push_pull <=
				output_type_pin_function[`IOPFS_BIT_G1_PUSHPULL];
			cfg.thermal_shutdown_enable <=
				output_type_pin_function[`IOPFS_BIT_THERM_EN];
			cfg.bank_function <= bank;
			cfg.debounce_disable <=
				debounce_trigger_select[`IOPFS_DEB_LO +: 3];
			cfg.level_trigger <=
				debounce_trigger_select[`IOPFS_TRIG_LO +: 3];
		end
	end

	// Bank pin routing; pin 0 and pin 1 are the two special pins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bank_gpio_sel <= 8'hfc;
			bank_serial_sel <= 8'h00;
			bank_pin0_tristate <= 1'b1;
			bank_pin1_force_low <= 1'b1;
			bank_ir_sel <= 1'b0;
		end else begin
			case (bank)
				IOPFS_BANK_RESERVED: begin
					bank_gpio_sel <= 8'hfc;
					bank_serial_sel <= 8'h00;
					bank_pin0_tristate <= 1'b1;
					bank_pin1_force_low <= 1'b1;
					bank_ir_sel <= 1'b0;
				end
				IOPFS_BANK_INFRARED: begin
					bank_gpio_sel <= 8'hfc;
					bank_serial_sel <= 8'h00;
					bank_pin0_tristate <= 1'b0;
					bank_pin1_force_low <= 1'b0;
					bank_ir_sel <= 1'b1;
				end
				IOPFS_BANK_GPIO: begin
					bank_gpio_sel <= 8'hff;
					bank_serial_sel <= 8'h00;
					bank_pin0_tristate <= 1'b0;
					bank_pin1_force_low <= 1'b0;
					bank_ir_sel <= 1'b0;
				end
				default: begin
					bank_gpio_sel <= 8'h00;
					bank_serial_sel <= 8'hff;
					bank_pin0_tristate <= 1'b0;
					bank_pin1_force_low <= 1'b0;
					bank_ir_sel <= 1'b0;
				end
			endcase
		end
	end

	a_ack_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	a_i2c_route: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.i2c_pins == $past(i2c_pin_select[1]))
		else $error("i2c routing wrong");
	a_sda_filter: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.sda_bypass == $past(i2c_pin_select[3]))
		else $error("data filter wrong");
	a_scl_filter: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.scl_bypass == $past(i2c_pin_select[2]))
		else $error("clock filter wrong");
	a_i2c_reserved: assert property (@(posedge clk) disable iff (!reset_n)
		(i2c_pin_select & 8'hf1) == 8'h00)
		else $error("reserved bits set");
	a_group_two: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.group_two_push_pull == $past(output_type_pin_function[7]))
		else $error("group two drive wrong");
	a_group_one: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.group_one_push_pull == $past(output_type_pin_function[6]))
		else $error("group one drive wrong");
	a_thermal_en: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.thermal_shutdown_enable == $past(output_type_pin_function[2]))
		else $error("thermal enable wrong");
	a_bank_reserved: assert property (@(posedge clk) disable iff (!reset_n)
		bank == IOPFS_BANK_RESERVED |=> bank_pin0_tristate &&
		bank_pin1_force_low && bank_gpio_sel == 8'hfc)
		else $error("reserved bank wrong");
	a_bank_ir: assert property (@(posedge clk) disable iff (!reset_n)
		bank == IOPFS_BANK_INFRARED |=> bank_ir_sel && !bank_pin0_tristate
		&& bank_gpio_sel == 8'hfc) else $error("infrared bank wrong");
	a_bank_serial: assert property (@(posedge clk) disable iff (!reset_n)
		bank == IOPFS_BANK_SERIAL |=> bank_serial_sel == 8'hff &&
		bank_gpio_sel == 8'h00) else $error("serial bank wrong");
	a_debounce: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.debounce_disable == $past(debounce_trigger_select[6:4]))
		else $error("debounce wrong");
	a_trigger: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.level_trigger == $past(debounce_trigger_select[2:0]))
		else $error("trigger wrong");
	a_deb_reserved: assert property (@(posedge clk) disable iff (!reset_n)
		(debounce_trigger_select & 8'h88) == 8'h00)
		else $error("debounce reserved set");

	// Bus handshake: one registered ack per taken request
	a_ack_follows_req: assert property (@(posedge clk)
		disable iff (!reset_n)
		access |=> wb_ack_o)
		else $error("request not acked");
	a_ack_needs_req: assert property (@(posedge clk)
		disable iff (!reset_n)
		!access |=> !wb_ack_o)
		else $error("ack without request");
	a_dat_idle_zero: assert property (@(posedge clk)
		disable iff (!reset_n)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	a_dat_upper_zero: assert property (@(posedge clk)
		disable iff (!reset_n)
		wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read data set");

	// Read data reflects the addressed register
	a_read_i2c: assert property (@(posedge clk) disable iff (!reset_n)
		access && wb_req.adr == `IOPFS_IDX_I2C_SEL
		|=> wb_dat_o[7:0] == $past(i2c_pin_select))
		else $error("i2c select read wrong");
	a_read_out_func: assert property (@(posedge clk) disable iff (!reset_n)
		access && wb_req.adr == `IOPFS_IDX_OUT_FUNC
		|=> wb_dat_o[7:0] == $past(output_type_pin_function))
		else $error("output type read wrong");
	a_read_deb: assert property (@(posedge clk) disable iff (!reset_n)
		access && wb_req.adr == `IOPFS_IDX_DEB_TRIG
		|=> wb_dat_o[7:0] == $past(debounce_trigger_select))
		else $error("debounce read wrong");
	a_read_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
		access && wb_req.adr == `IOPFS_IDX_RSVD
		|=> wb_dat_o == 32'h0000_0000)
		else $error("reserved register read");

	// Writes land masked; nothing else moves the registers
	a_write_i2c: assert property (@(posedge clk) disable iff (!reset_n)
		wr && wb_req.adr == `IOPFS_IDX_I2C_SEL |=> i2c_pin_select ==
		($past(wb_req.dat) & `IOPFS_I2C_SEL_MASK))
		else $error("i2c select write lost");
	a_write_out_func: assert property (@(posedge clk) disable iff (!reset_n)
		wr && wb_req.adr == `IOPFS_IDX_OUT_FUNC |=> output_type_pin_function
		== ($past(wb_req.dat) & `IOPFS_OUT_FUNC_MASK))
		else $error("output type write lost");
	a_write_deb: assert property (@(posedge clk) disable iff (!reset_n)
		wr && wb_req.adr == `IOPFS_IDX_DEB_TRIG |=> debounce_trigger_select
		== ($past(wb_req.dat) & `IOPFS_DEB_TRIG_MASK))
		else $error("debounce write lost");
	a_sel_ignored: assert property (@(posedge clk) disable iff (!reset_n)
		access && wb_req.we && !wb_req.sel |=> $stable(i2c_pin_select) &&
		$stable(output_type_pin_function) && $stable(debounce_trigger_select))
		else $error("unselected write landed");
	a_i2c_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr && wb_req.adr == `IOPFS_IDX_I2C_SEL)
		|=> $stable(i2c_pin_select))
		else $error("i2c select changed");
	a_out_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr && wb_req.adr == `IOPFS_IDX_OUT_FUNC)
		|=> $stable(output_type_pin_function))
		else $error("output type changed");
	a_deb_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(wr && wb_req.adr == `IOPFS_IDX_DEB_TRIG)
		|=> $stable(debounce_trigger_select))
		else $error("debounce changed");
	a_out_reserved: assert property (@(posedge clk) disable iff (!reset_n)
		(output_type_pin_function & 8'h38) == 8'h00)
		else $error("output type reserved set");

	// Bank routing, case by case and across outputs
	a_bank_gpio: assert property (@(posedge clk) disable iff (!reset_n)
		bank == IOPFS_BANK_GPIO |=> bank_gpio_sel == 8'hff &&
		bank_serial_sel == 8'h00 && !bank_pin0_tristate && !bank_pin1_force_low)
		else $error("gpio bank wrong");
	a_bank_ir_pins: assert property (@(posedge clk) disable iff (!reset_n)
		bank == IOPFS_BANK_INFRARED |=> !bank_pin1_force_low &&
		bank_serial_sel == 8'h00)
		else $error("infrared pins wrong");
	a_bank_res_more: assert property (@(posedge clk) disable iff (!reset_n)
		bank == IOPFS_BANK_RESERVED |=> !bank_ir_sel &&
		bank_serial_sel == 8'h00)
		else $error("reserved bank extra");
	a_serial_pins: assert property (@(posedge clk) disable iff (!reset_n)
		bank == IOPFS_BANK_SERIAL |=> !bank_pin0_tristate &&
		!bank_pin1_force_low && !bank_ir_sel)
		else $error("serial pins wrong");
	a_ir_only_bank: assert property (@(posedge clk) disable iff (!reset_n)
		bank_ir_sel |-> cfg.bank_function == IOPFS_BANK_INFRARED)
		else $error("infrared outside mode");
	a_tristate_bank: assert property (@(posedge clk) disable iff (!reset_n)
		bank_pin0_tristate |-> cfg.bank_function == IOPFS_BANK_RESERVED)
		else $error("tristate outside mode");
	a_low_only_bank: assert property (@(posedge clk) disable iff (!reset_n)
		bank_pin1_force_low |-> cfg.bank_function == IOPFS_BANK_RESERVED)
		else $error("low pin outside mode");
	a_gpio_serial_excl: assert property (@(posedge clk)
		disable iff (!reset_n)
		(bank_gpio_sel & bank_serial_sel) == 8'h00)
		else $error("pin both gpio and serial");
	a_bank_cfg: assert property (@(posedge clk) disable iff (!reset_n)
		##1 cfg.bank_function == $past(bank))
		else $error("bank function wrong");
	a_gpio_upper: assert property (@(posedge clk) disable iff (!reset_n)
		bank_gpio_sel[7:2] == 6'h3f || bank_serial_sel == 8'hff)
		else $error("upper bank pins lost");
endmodule : iopfs_top

// File: iopfs_pin_model.sv
// Board side of the eight-pin bank: levels seen on the two special pins.
// Assumes pull-ups on both pins and an idle-high infrared transmitter.
`timescale 1ns/1ps
module iopfs_pin_model (
	// Pad controls from the block
	input wire logic pin0_tristate,
	input wire logic pin1_force_low,
	input wire logic ir_sel,
	// Pin levels
	output logic pin0_level,
	output logic pin1_level
);
	assign pin0_level = 1'b1;
	assign pin1_level = pin1_force_low ? 1'b0 : 1'b1;
endmodule : iopfs_pin_model

// File: io_pin_function_select_tb_top.sv
// Register tests of the pin function select block over Wishbone.
// Assumes one clock and a registered ack one cycle after the request.
`timescale 1ns/1ps
module io_pin_function_select_tb_top;
	import iopfs_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	iopfs_wb_req_t req = '0;
	logic [31:0] dat;
	logic ack;
	iopfs_cfg_t cfg;
	logic [7:0] gsel, ssel, q, v;
	logic p0t, p1l, irs, p0, p1;
	logic [2:0] f;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc_n = 0;
	iopfs_top i_iopfs_top (.clk(clk), .reset_n(reset_n), .wb_req(req),
		.wb_dat_o(dat), .wb_ack_o(ack), .cfg(cfg), .bank_gpio_sel(gsel),
		.bank_serial_sel(ssel), .bank_pin0_tristate(p0t),
		.bank_pin1_force_low(p1l), .bank_ir_sel(irs));
	iopfs_pin_model i_iopfs_pin_model (.pin0_tristate(p0t),
		.pin1_force_low(p1l), .ir_sel(irs), .pin0_level(p0),
		.pin1_level(p1));
	initial begin
		forever #50 clk = ~clk;
	end
	task end_of_test;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n > 3000) begin
			num_errors++;
			end_of_test();
		end
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One classic cycle; data taken and request released at the ack edge
	task wb(input logic [7:0] a, d, input logic w, s, output logic [7:0] r);
		@(posedge clk);
		req <= '{a, d, w, s, 1'b1, 1'b1};
		do @(posedge clk); while (ack !== 1'b1);
		r = dat[7:0];
		req <= '0;
	endtask : wb
	task settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		chk("bank_gpio", 8'hfc, gsel);
		chk("pin1", 8'h00, {7'h0, p1});
		wb(8'h2a, 8'h00, 1'b0, 1'b1, q);
		chk("i2c_sel", 8'h00, q);
		wb(8'h2d, 8'h00, 1'b0, 1'b1, q);
		chk("deb_trig", 8'h00, q);
		wb(8'h2a, 8'hff, 1'b1, 1'b1, q);
		wb(8'h2a, 8'h00, 1'b1, 1'b0, q);
		wb(8'h2a, 8'h00, 1'b0, 1'b1, q);
		chk("i2c_sel", 8'h0e, q);
		settle();
		chk("i2c_cfg", 8'h07,
			{5'h0, cfg.sda_bypass, cfg.scl_bypass, cfg.i2c_pins});
		wb(8'h2a, 8'h08, 1'b1, 1'b1, q);
		settle();
		chk("i2c_cfg", 8'h04,
			{5'h0, cfg.sda_bypass, cfg.scl_bypass, cfg.i2c_pins});
		wb(8'h2b, 8'hff, 1'b1, 1'b1, q);
		wb(8'h2b, 8'h00, 1'b0, 1'b1, q);
		chk("rsvd", 8'h00, q);
		wb(8'h2d, 8'hff, 1'b1, 1'b1, q);
		wb(8'h2d, 8'h00, 1'b0, 1'b1, q);
		chk("deb_trig", 8'h77, q);
		wb(8'h2d, 8'h21, 1'b1, 1'b1, q);
		settle();
		chk("deb_cfg", 8'h11,
			{2'h0, cfg.debounce_disable, cfg.level_trigger});
		for (f = 3'h0; f < 3'h4; f++) begin
			v = {f[1:0], 3'h7, f[0], f[1:0]};
			wb(8'h2c, v, 1'b1, 1'b1, q);
			wb(8'h2c, 8'h00, 1'b0, 1'b1, q);
			chk("out_func", {f[1:0], 3'h0, f[0], f[1:0]}, q);
			settle();
			chk("ctl", {f[1:0], f[0], f == 3'h0, f == 3'h0, f == 3'h1,
				f[1:0]}, {cfg.group_two_push_pull, cfg.group_one_push_pull,
				cfg.thermal_shutdown_enable, p0t, p1l, irs,
				cfg.bank_function});
			chk("bank_gpio", f == 3'h3 ? 8'h00 : f == 3'h2 ? 8'hff : 8'hfc,
				gsel);
			chk("bank_serial", f == 3'h3 ? 8'hff : 8'h00, ssel);
			chk("pin1", {7'h0, f != 3'h0}, {7'h0, p1});
		end
		end_of_test();
	end
endmodule : io_pin_function_select_tb_top
